// file: design/cdec_core.sv
// decode and execute slice for move, or, multiply and negate instructions
//
// Contract
// - or literal into accumulator, only n z flags
// - or file into destination, only n z flags
// - destination bit zero accumulator, one file
// - bank bit zero access bank, one bank register
// - eight bit address covers whole selected bank
// - pointer load two words, high then low
// - file move to destination, n z flags
// - two word move, twelve bit addresses, no flags
// - move reads first cycle, writes second end
// - bank load literal, one cycle, no flags
// - literal move into accumulator, no flags
// - accumulator store to file, no flags
// - literal multiply into product pair
// - file multiply into product, operands kept
// - multiplies one cycle, never touch flags
// - negate file byte, five flags updated
module cdec_core
   import cdec_pkg::*;
(
   // clock and reset
   input  wire logic           clk_sys_in,
   input  wire logic           rstn_in,
   // apb slave
   input  wire logic           psel_in,
   input  wire logic           penable_in,
   input  wire logic           pwrite_in,
   input  wire logic [11:0]    paddr_in,
   input  wire logic [31:0]    pwdata_in,
   output logic      [31:0]    prdata_out,
   output logic                pready_out,
   output logic                pslverr_out,
   // instruction fetch
   input  wire logic           instr_valid_in,
   input  wire logic [15:0]    instr_word_in,
   output logic                instr_ack_out,
   output logic      [1:0]     phase_out,
   // banked data file
   output cdec_file_req_t      file_req_out,
   input  wire logic [7:0]     file_rdata_in
);

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rstn_in);

   logic [1:0]     phase_q;            // current quarter of the cycle
   cdec_state_t    state_q;            // first or second word expected
   cdec_state_t    state_d;            // state after this execute
   logic [15:0]    instr_q;            // word taken at the cycle start
   logic           cur_valid_q;        // a word was taken this cycle
   logic           ack_q;              // word consumed pulse
   logic           run_q;              // software run enable
   logic [7:0]     acc_q;              // working_accumulator
   logic [7:0]     bank_q;             // bank_select_reg
   logic [15:0]    prod_q;             // product_high_byte:low byte
   logic [4:0]     flags_q;            // n ovf z dig c
   logic [7:0]     hold_q;             // source byte of file move
   logic [1:0]     ptr_sel_q;          // pointer picked by first word
   logic [11:0]    ptr_q [PTR_COUNT];  // file_select_pointer set
   cdec_file_req_t file_req_q;         // registered file request
   logic           pready_q;           // apb answer
   logic           pslverr_q;          // apb error answer
   logic [31:0]    prdata_q;           // apb read data

   logic           take;               // word accepted at this edge
   logic           ex_go;              // execute edge of a live cycle
   logic [7:0]     k;                  // immediate byte
   logic           dec_or_lit;
   logic           dec_bank_load;
   logic           dec_lit_move;
   logic           dec_lit_mul;
   logic           dec_or_file;
   logic           dec_file_move;
   logic           dec_acc_store;
   logic           dec_negate;
   logic           dec_file_mul;
   logic           dec_ptr_load;
   logic           dec_f2f;
   logic [7:0]     ex_res;             // alu result byte
   logic           ex_dest;            // result follows destination bit
   logic           ex_file_we;         // write file in q4
   logic [7:0]     ex_wdata;           // byte to write
   logic           ex_acc_we;
   logic [7:0]     ex_acc;
   logic           ex_nz;              // update n and z only
   logic           ex_neg;             // update all five flags
   logic           ex_prod_we;
   logic [15:0]    ex_prod;
   logic           ex_bank_we;
   logic           ex_ptr_hi_we;
   logic           ex_ptr_lo_we;
   logic           ex_hold_we;
   logic [31:0]    rd_mux;             // apb read value
   logic           rd_hit;             // apb address is mapped
   logic [31:0]    ptr_rd [PTR_COUNT]; // pointer read lanes
   logic [PTR_COUNT-1:0] ptr_hit;      // pointer address match

   // bank or access page address of a single-word file instruction
   function automatic logic [11:0] file_addr(input logic [15:0] w,
                                             input logic [7:0]  bank);
      if (!w[BIT_BANK]) begin
         // access bank overrides the bank register
         if (w[7:0] < ACCESS_SPLIT) begin
            return {ACCESS_LOW_PAGE, w[7:0]};
         end
         return {ACCESS_HIGH_PAGE, w[7:0]};
      end
      // eight bit offset reaches every byte of the bank
      return {bank[3:0], w[7:0]};
   endfunction : file_addr

   // single-word instructions that read a file byte in q2
   function automatic logic reads_file(input logic [15:0] w);
      return (w[15:10] == OP_OR_FILE) || (w[15:10] == OP_FILE_MOVE) ||
             (w[15:9] == OP_ACC_STORE) || (w[15:9] == OP_NEGATE) ||
             (w[15:9] == OP_FILE_MUL);
   endfunction : reads_file

   assign take  = (phase_q == PH_Q1) && run_q && instr_valid_in;
   assign ex_go = cur_valid_q && (phase_q == PH_Q3);
   assign k     = instr_q[7:0];

   // opcode decode of the held word
   assign dec_or_lit    = instr_q[15:8] == OP_OR_LITERAL;
   assign dec_bank_load = instr_q[15:8] == OP_BANK_LOAD;
   assign dec_lit_move  = instr_q[15:8] == OP_LITERAL_MOVE;
   assign dec_lit_mul   = instr_q[15:8] == OP_LITERAL_MUL;
   assign dec_or_file   = instr_q[15:10] == OP_OR_FILE;
   assign dec_file_move = instr_q[15:10] == OP_FILE_MOVE;
   assign dec_acc_store = instr_q[15:9] == OP_ACC_STORE;
   assign dec_negate    = instr_q[15:9] == OP_NEGATE;
   assign dec_file_mul  = instr_q[15:9] == OP_FILE_MUL;
   assign dec_ptr_load  = instr_q[15:6] == OP_PTR_LOAD;
   assign dec_f2f       = instr_q[15:12] == OP_F2F_SRC;

   // quarter counter, free running
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         phase_q <= PH_Q1;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // fetch: one word per cycle, sampled only at the q1 edge
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         cur_valid_q <= 1'b0;
         ack_q       <= 1'b0;
         instr_q     <= 16'h0000;
      end else begin
         ack_q <= take;
         if (phase_q == PH_Q1) begin
            cur_valid_q <= take;
            if (take) begin
               instr_q <= instr_word_in;
            end
         end
      end
   end

   // execute decode; unknown words fall through as idle
   always_comb begin
      ex_res       = 8'h00;
      ex_dest      = 1'b0;
      ex_file_we   = 1'b0;
      ex_wdata     = 8'h00;
      ex_acc_we    = 1'b0;
      ex_acc       = 8'h00;
      ex_nz        = 1'b0;
      ex_neg       = 1'b0;
      ex_prod_we   = 1'b0;
      ex_prod      = 16'h0000;
      ex_bank_we   = 1'b0;
      ex_ptr_hi_we = 1'b0;
      ex_ptr_lo_we = 1'b0;
      ex_hold_we   = 1'b0;
      state_d      = state_q;
      case (state_q)
         ST_FIRST: begin
            if (dec_or_lit) begin
               ex_res    = acc_q | k;
               ex_acc_we = 1'b1;
               ex_acc    = ex_res;
               ex_nz     = 1'b1;
            end else if (dec_bank_load) begin
               ex_bank_we = 1'b1;
            end else if (dec_lit_move) begin
               ex_acc_we = 1'b1;
               ex_acc    = k;
            end else if (dec_lit_mul) begin
               ex_prod_we = 1'b1;
               ex_prod    = {8'h00, acc_q} * {8'h00, k};
            end else if (dec_or_file) begin
               ex_res  = acc_q | file_rdata_in;
               ex_dest = 1'b1;
               ex_nz   = 1'b1;
            end else if (dec_file_move) begin
               ex_res  = file_rdata_in;
               ex_dest = 1'b1;
               ex_nz   = 1'b1;
            end else if (dec_acc_store) begin
               ex_file_we = 1'b1;
               ex_wdata   = acc_q;
            end else if (dec_negate) begin
               ex_res     = 8'h00 - file_rdata_in;
               ex_file_we = 1'b1;
               ex_wdata   = ex_res;
               ex_neg     = 1'b1;
            end else if (dec_file_mul) begin
               // neither operand is written back
               ex_prod_we = 1'b1;
               ex_prod    = {8'h00, acc_q} * {8'h00, file_rdata_in};
            end else if (dec_ptr_load) begin
               ex_ptr_hi_we = 1'b1;
               state_d      = ST_PTR_LOW;
            end else if (dec_f2f) begin
               ex_hold_we = 1'b1;
               state_d    = ST_MOVE_DST;
            end
            // zero word and 1111 words stay idle here
         end
         ST_PTR_LOW: begin
            ex_ptr_lo_we = instr_q[15:8] == OP_PTR_SECOND;
            state_d      = ST_FIRST;
         end
         ST_MOVE_DST: begin
            // target restriction is left to software
            ex_file_we = instr_q[15:12] == OP_SECOND;
            ex_wdata   = hold_q;
            state_d    = ST_FIRST;
         end
         default: begin
            state_d = ST_FIRST;
         end
      endcase
      // destination bit picks file or accumulator
      if (ex_dest) begin
         if (instr_q[BIT_DEST]) begin
            ex_file_we = 1'b1;
            ex_wdata   = ex_res;
         end else begin
            ex_acc_we = 1'b1;
            ex_acc    = ex_res;
         end
      end
   end

   // sequencer state, moved only at the execute edge
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         state_q   <= ST_FIRST;
         hold_q    <= 8'h00;
         ptr_sel_q <= 2'h0;
      end else if (ex_go) begin
         state_q <= state_d;
         if (ex_hold_we) begin
            hold_q <= file_rdata_in;
         end
         if (ex_ptr_hi_we) begin
            ptr_sel_q <= instr_q[5:4];
         end
      end
   end

   // accumulator, bank register and product pair
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         acc_q  <= ACC_RESET;
         bank_q <= BANK_RESET;
         prod_q <= PROD_RESET;
      end else if (ex_go) begin
         if (ex_acc_we) begin
            acc_q <= ex_acc;
         end
         if (ex_bank_we) begin
            bank_q <= k;
         end
         if (ex_prod_we) begin
            prod_q <= ex_prod;
         end
      end
   end

   // status flags; multiplies, literal moves and two-word moves leave them alone
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         flags_q <= FLAGS_RESET;
      end else if (ex_go) begin
         if (ex_neg) begin
            // borrow style carry: set only when the operand was zero
            flags_q[FLG_C]   <= file_rdata_in == 8'h00;
            flags_q[FLG_DIG] <= file_rdata_in[3:0] == 4'h0;
            flags_q[FLG_OVF] <= file_rdata_in == 8'h80;
            flags_q[FLG_N]   <= ex_res[7];
            flags_q[FLG_Z]   <= ex_res == 8'h00;
         end else if (ex_nz) begin
            flags_q[FLG_N] <= ex_res[7];
            flags_q[FLG_Z] <= ex_res == 8'h00;
         end
      end
   end

   // file select pointers; a select of 3 writes nothing
   for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
      always_ff @(posedge clk_sys_in) begin
         if (!rstn_in) begin
            ptr_q[i] <= PTR_RESET;
         end else if (ex_go && ex_ptr_hi_we && instr_q[5:4] == 2'(i)) begin
            ptr_q[i][11:8] <= instr_q[3:0];
         end else if (ex_go && ex_ptr_lo_we && ptr_sel_q == 2'(i)) begin
            ptr_q[i][7:0] <= k;
         end
      end
      assign ptr_hit[i] = paddr_in == REG_PTR_BASE + 12'(PTR_STRIDE * i);
      assign ptr_rd[i]  = ptr_hit[i] ? {20'h00000, ptr_q[i]} : 32'h0;
   end

   // file request: read in q2, write in q4
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         file_req_q <= '0;
      end else begin
         case (phase_q)
            PH_Q1: begin
               if (take && state_q == ST_FIRST &&
                   reads_file(instr_word_in)) begin
                  file_req_q.addr <= file_addr(instr_word_in, bank_q);
                  file_req_q.rd   <= 1'b1;
               end else if (take && state_q == ST_FIRST &&
                            instr_word_in[15:12] == OP_F2F_SRC) begin
                  file_req_q.addr <= instr_word_in[11:0];
                  file_req_q.rd   <= 1'b1;
               end else if (take && state_q == ST_MOVE_DST) begin
                  // dummy read of the move target
                  file_req_q.addr <= instr_word_in[11:0];
                  file_req_q.rd   <= 1'b1;
               end
            end
            PH_Q2: begin
               file_req_q.rd <= 1'b0;
            end
            PH_Q3: begin
               if (ex_go && ex_file_we) begin
                  file_req_q.wr    <= 1'b1;
                  file_req_q.wdata <= ex_wdata;
               end
            end
            default: begin
               file_req_q.wr <= 1'b0;
            end
         endcase
      end
   end

   // apb read mux; pointers fill the unnamed offsets
   always_comb begin
      rd_hit = 1'b1;
      case (paddr_in)
         REG_CTRL: rd_mux = {31'h00000000, run_q};
         REG_CORE: rd_mux = {11'h000, flags_q, bank_q, acc_q};
         REG_PROD: rd_mux = {16'h0000, prod_q};
         default: begin
            rd_mux = 32'h0;
            for (int j = 0; j < PTR_COUNT; j++) begin
               rd_mux = rd_mux | ptr_rd[j];
            end
            rd_hit = |ptr_hit;
         end
      endcase
   end

   // apb slave: one wait state, error on unmapped or read-only write
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
         run_q     <= RUN_RESET;
      end else begin
         pready_q  <= psel_in && penable_in && !pready_q;
         pslverr_q <= 1'b0;
         if (psel_in && penable_in && !pready_q) begin
            if (pwrite_in) begin
               if (paddr_in == REG_CTRL) begin
                  run_q <= pwdata_in[BIT_RUN];
               end else begin
                  pslverr_q <= 1'b1;
               end
            end else begin
               prdata_q  <= rd_mux;
               pslverr_q <= !rd_hit;
            end
         end
      end
   end

   assign prdata_out    = prdata_q;
   assign pready_out    = pready_q;
   assign pslverr_out   = pslverr_q;
   assign instr_ack_out = ack_q;
   assign phase_out     = phase_q;
   assign file_req_out  = file_req_q;

   // checks next to the execute logic
   sequence s_first_go;
      ex_go && state_q == ST_FIRST;
   endsequence
   sequence s_q4_write;
      file_req_q.wr ##1 !file_req_q.wr;
   endsequence

   property p_or_lit;
      s_first_go and dec_or_lit |=> acc_q == ($past(acc_q) | $past(k)) &&
         flags_q[FLG_C] == $past(flags_q[FLG_C]);
   endproperty
   a_or_lit: assert property (p_or_lit)
      else $error("or literal result wrong");

   property p_dest_file;
      s_first_go and (dec_or_file || dec_file_move) && instr_q[BIT_DEST]
         |=> s_q4_write ##0 $stable(acc_q);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("file destination not written");

   property p_bank_addr;
      take && state_q == ST_FIRST && reads_file(instr_word_in) &&
         instr_word_in[BIT_BANK] |=>
         file_req_q.addr == {$past(bank_q[3:0]), $past(instr_word_in[7:0])};
   endproperty
   a_bank_addr: assert property (p_bank_addr)
      else $error("banked address wrong");

   property p_f2f_src;
      s_first_go and dec_f2f |=> state_q == ST_MOVE_DST &&
         hold_q == $past(file_rdata_in) && $stable(flags_q);
   endproperty
   a_f2f_src: assert property (p_f2f_src)
      else $error("move source not held");

   property p_f2f_dst;
      ex_go && state_q == ST_MOVE_DST && instr_q[15:12] == OP_SECOND
         |=> s_q4_write ##0 (file_req_q.wdata == $past(hold_q, 2));
   endproperty
   a_f2f_dst: assert property (p_f2f_dst)
      else $error("move destination not written");

   property p_bank_load;
      s_first_go and dec_bank_load |=> bank_q == $past(k) && $stable(flags_q);
   endproperty
   a_bank_load: assert property (p_bank_load)
      else $error("bank load wrong");

   property p_lit_mul;
      s_first_go and dec_lit_mul |=> prod_q == $past(acc_q) * $past(k) &&
         $stable(acc_q) && $stable(flags_q);
   endproperty
   a_lit_mul: assert property (p_lit_mul)
      else $error("literal multiply wrong");

   property p_negate;
      s_first_go and dec_negate |=> file_req_q.wr &&
         file_req_q.wdata == 8'h00 - $past(file_rdata_in) &&
         flags_q[FLG_Z] == ($past(file_rdata_in) == 8'h00);
   endproperty
   a_negate: assert property (p_negate)
      else $error("negate result wrong");

   property p_idle;
      s_first_go and instr_q == 16'h0000 |=> $stable(acc_q) &&
         $stable(flags_q) && $stable(prod_q) && !file_req_q.wr;
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle word changed state");

endmodule : cdec_core

// file: design/cdec_pkg.sv
// constants, encodings and carrier types for the move and multiply core slice
package cdec_pkg;

   // four phases make one instruction cycle
   localparam logic [1:0]  PH_Q1            = 2'h0; // decode, fetch taken
   localparam logic [1:0]  PH_Q2            = 2'h1; // file read
   localparam logic [1:0]  PH_Q3            = 2'h2; // process data
   localparam logic [1:0]  PH_Q4            = 2'h3; // write destination

   // opcode patterns, compared against the top bits of a word
   localparam logic [7:0]  OP_OR_LITERAL    = 8'h09;  // 0000 1001
   localparam logic [7:0]  OP_BANK_LOAD     = 8'h01;  // 0000 0001
   localparam logic [7:0]  OP_LITERAL_MOVE  = 8'h0e;  // 0000 1110
   localparam logic [7:0]  OP_LITERAL_MUL   = 8'h0d;  // 0000 1101
   localparam logic [5:0]  OP_OR_FILE       = 6'h04;  // 0001 00
   localparam logic [5:0]  OP_FILE_MOVE     = 6'h14;  // 0101 00
   localparam logic [6:0]  OP_ACC_STORE     = 7'h37;  // 0110 111
   localparam logic [6:0]  OP_NEGATE        = 7'h36;  // 0110 110
   localparam logic [6:0]  OP_FILE_MUL      = 7'h01;  // 0000 001
   localparam logic [9:0]  OP_PTR_LOAD      = 10'h3b8; // 1110 1110 00
   localparam logic [3:0]  OP_F2F_SRC       = 4'hc;   // first move word
   localparam logic [3:0]  OP_SECOND        = 4'hf;   // any second word
   localparam logic [7:0]  OP_PTR_SECOND    = 8'hf0;  // pointer low word

   // instruction field positions
   localparam int          BIT_DEST         = 9;
   localparam int          BIT_BANK         = 8;

   // access bank split: low half maps to page 0, upper half to page f
   localparam logic [7:0]  ACCESS_SPLIT     = 8'h80;
   localparam logic [3:0]  ACCESS_LOW_PAGE  = 4'h0;
   localparam logic [3:0]  ACCESS_HIGH_PAGE = 4'hf;

   // number of file select pointers
   localparam int          PTR_COUNT        = 3;

   // status flag positions
   localparam int          FLG_C            = 0;
   localparam int          FLG_DIG          = 1;
   localparam int          FLG_Z            = 2;
   localparam int          FLG_OVF          = 3;
   localparam int          FLG_N            = 4;

   // values after reset
   localparam logic [7:0]  ACC_RESET        = 8'h00;
   localparam logic [7:0]  BANK_RESET       = 8'h00;
   localparam logic [15:0] PROD_RESET       = 16'h0000;
   localparam logic [11:0] PTR_RESET        = 12'h000;
   localparam logic [4:0]  FLAGS_RESET      = 5'h00;
   localparam logic        RUN_RESET        = 1'b1;

   // apb register byte offsets
   localparam logic [11:0] REG_CTRL         = 12'h000;
   localparam logic [11:0] REG_CORE         = 12'h004;
   localparam logic [11:0] REG_PROD         = 12'h008;
   localparam logic [11:0] REG_PTR_BASE     = 12'h00c;
   localparam logic [11:0] PTR_STRIDE       = 12'h004;
   localparam int          BIT_RUN          = 0;

   // sequencer state across two-word instructions
   typedef enum logic [1:0] {
      ST_FIRST    = 2'b00,
      ST_PTR_LOW  = 2'b01,
      ST_MOVE_DST = 2'b10
   } cdec_state_t;

   // request toward the banked data file
   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } cdec_file_req_t;

endpackage : cdec_pkg

// file: tb/cdec_file_model.sv
// banked data file model: reads answer one clock later, then scramble
module cdec_file_model
   import cdec_pkg::*;
(
   // clock and requests
   input  wire logic           clk_sys_in,
   input  wire cdec_file_req_t req_in,
   // read data
   output logic [7:0]          rdata_out = 8'h5a
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [4096]; // whole data space, bench preloads it
   // data only valid in the clock after rd, so a late sample sees junk
   always @(posedge clk_sys_in) begin
      if (req_in.rd)
         rdata_out <= mem[req_in.addr];
      else
         rdata_out <= ~rdata_out;
      if (req_in.wr)
         mem[req_in.addr] <= req_in.wdata;
   end
endmodule : cdec_file_model

// file: tb/cdec_core_test.sv
// self-checking bench for the move and multiply core slice
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module cdec_core_test
   import cdec_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in, rstn_in, psel, pen, pwr, perr, pready, ivld, ack;
   logic [11:0] paddr, ptr [3];
   logic [31:0] pwdata, prdata;
   logic [15:0] iword, prod;
   logic [1:0] ph;
   cdec_file_req_t req;
   logic [7:0] rdata, acc, bank, sh [4096]; // expected core and file
   logic [4:0] flg; // n ovf z dig c
   int seed = 75494, err_count = 0, checked = 0;
   cdec_core cdec_core_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(perr), .instr_valid_in(ivld), .instr_word_in(iword),
      .instr_ack_out(ack), .phase_out(ph), .file_req_out(req),
      .file_rdata_in(rdata));
   cdec_file_model cdec_file_model_i (.clk_sys_in(clk_sys_in),
      .req_in(req), .rdata_out(rdata));
   initial begin
      clk_sys_in = 0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // hang guard, well above the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_count++;
      stop_test();
   end
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   // apb master: hold request until pready is seen at an edge
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk_sys_in);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      pen <= 1;
      do @(posedge clk_sys_in); while (pready !== 1'b1);
      q = prdata;
      e = perr;
      psel <= 0;
      pen <= 0;
   endtask : apb
   task automatic chkreg(logic [11:0] a, logic [31:0] x, string n);
      logic [31:0] q;
      logic e;
      apb(0, a, 0, q, e);
      `CHK(n, x, q)
      `CHK("slverr", 1'b0, e)
   endtask : chkreg
   // offer a word so that the next edge is a q1 edge
   // x is the acknowledge expected one clock after the q1 edge
   task automatic issue(logic [15:0] w, logic x);
      do @(posedge clk_sys_in); while (ph !== 2'h3);
      ivld <= 1;
      iword <= w;
      @(posedge clk_sys_in);
      ivld <= 0;
      iword <= 16'($random(seed)); // junk while not valid
      @(posedge clk_sys_in);
      `CHK("ack", x, ack)
   endtask : issue
   function automatic logic [11:0] fa(logic [7:0] f, logic a);
      if (a)
         return {bank[3:0], f};
      return {f < ACCESS_SPLIT ? ACCESS_LOW_PAGE : ACCESS_HIGH_PAGE, f};
   endfunction : fa
   task automatic dst(logic d, logic [7:0] f, logic a, logic [7:0] v);
      if (d)
         sh[fa(f, a)] = v;
      else
         acc = v;
      flg[FLG_N] = v[7];
      flg[FLG_Z] = v == 8'h00;
   endtask : dst
   // one random instruction, then the expected state is compared
   task automatic step();
      logic [7:0] k, f, r;
      logic [11:0] x, y;
      logic [1:0] s;
      logic d, a;
      logic [15:0] w;
      int c;
      {k, f, x, y, s, d, a} = 44'({$random(seed), $random(seed)});
      y[11] = 1'b0; // move target kept off the stack page
      c = $unsigned($random(seed)) % 12;
      r = sh[fa(f, a)];
      case (c)
         0: w = {OP_OR_LITERAL, k};
         1: w = {OP_OR_FILE, d, a, f};
         2: w = {OP_PTR_LOAD, s, x[11:8]};
         3: w = {OP_FILE_MOVE, d, a, f};
         4: w = {OP_F2F_SRC, x};
         5: w = {OP_BANK_LOAD, k};
         6: w = {OP_LITERAL_MOVE, k};
         7: w = {OP_ACC_STORE, a, f};
         8: w = {OP_LITERAL_MUL, k};
         9: w = {OP_FILE_MUL, a, f};
         10: w = {OP_NEGATE, a, f};
         default: w = d ? 16'h0000 : {4'hf, x};
      endcase
      issue(w, 1);
      if (c == 2)
         issue({OP_PTR_SECOND, x[7:0]}, 1);
      if (c == 4)
         issue({OP_SECOND, y}, 1);
      case (c)
         0: dst(0, f, a, acc | k);
         1: dst(d, f, a, acc | r);
         2: if (s != 2'h3) ptr[s] = x;
         3: dst(d, f, a, r);
         4: sh[y] = sh[x];
         5: bank = k;
         6: acc = k;
         7: sh[fa(f, a)] = acc;
         8: prod = acc * k;
         9: prod = acc * r;
         10: begin
            k = 8'h00 - r;
            sh[fa(f, a)] = k;
            flg = {k[7], r == 8'h80, r == 8'h00, r[3:0] == 4'h0, r == 8'h00};
         end
         default: ;
      endcase
      repeat (4) @(posedge clk_sys_in); // let the last write land
      chkreg(REG_CORE, {11'h0, flg, bank, acc}, "core");
      chkreg(REG_PROD, {16'h0, prod}, "prod");
   endtask : step
   initial begin
      logic [31:0] q;
      logic e;
      {psel, pen, pwr, ivld, paddr, pwdata, iword} = '0;
      rstn_in = 0;
      {acc, bank, prod, flg} = '0;
      ptr = '{3{12'h000}};
      for (int i = 0; i < 4096; i++) begin
         sh[i] = 8'($random(seed));
         cdec_file_model_i.mem[i] = sh[i];
      end
      repeat (3) @(posedge clk_sys_in);
      rstn_in <= 1;
      chkreg(REG_CTRL, 32'h1, "ctrl");
      chkreg(REG_CORE, 32'h0, "core");
      $display("test reset done");
      apb(0, 12'h018, 0, q, e);
      `CHK("unmapped", 1'b1, e)
      apb(1, REG_CTRL, 0, q, e);
      issue({OP_LITERAL_MOVE, 8'h5a}, 0); // stopped core ignores it
      apb(1, REG_CTRL, 1, q, e);
      apb(1, REG_CORE, 32'hff, q, e); // read-only word refuses writes
      `CHK("ro write", 1'b1, e)
      chkreg(REG_CORE, 32'h0, "stopped");
      $display("test refusal done");
      repeat (300) step();
      // second word with a wrong tag: nothing moves, word not executed
      issue({OP_F2F_SRC, 12'h010}, 1);
      issue({OP_LITERAL_MOVE, 8'h77}, 1);
      repeat (4) @(posedge clk_sys_in);
      chkreg(REG_CORE, {11'h0, flg, bank, acc}, "badtag");
      for (int i = 0; i < 3; i++)
         chkreg(12'(REG_PTR_BASE + PTR_STRIDE * i), {20'h0, ptr[i]}, "ptr");
      for (int i = 0; i < 4096; i++)
         `CHK("mem", sh[i], cdec_file_model_i.mem[i])
      $display("test random done");
      stop_test();
   end
endmodule : cdec_core_test
